// [verilog/stc_device.sv]
/*
 * stc_device: sensor-side sample timing: clock select and divide, trigger and sync.
 * Assumes pins come from the host asynchronously; registers via the link port.
 */
// Overview of operation
// - external clock divided via ext_clk_divider field
// - divider value 0011 divides by four
// - internal 1.024 MHz time base by default
// - host clock on master or bit pin
// - divided clock 1024 or 256 kHz by mode
// - host sets clock only in standby
// - density output needs 768k or 1.024M
// - trigger only in low power SAR modes
// - one sample per trigger pulse
// - trigger_input_select picks frame sync or irq
// - trigger_enable bit turns triggering on
// - trigger pulses high, 5.7 us minimum
// - trigger rate not above sample rate
// - sync only in sigma-delta modes
// - sample_ready phase follows sync pulses
// - sync_input_select picks frame sync or irq
// - alignment_scheme 00 none, 01 sync, 10 interp
// - sync pulses high, 5.7 us minimum
// - scheme zero default, free running sampling
// - sample_ready on every new sample
// - clock_source_select picks internal or external
// - scheme 01 realigns to every pulse
// - scheme 10 outputs two-sample average
`timescale 1ns/1ns
`default_nettype none
module stc_device (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// link
	stc_link_if.device link,
	// sensor core
	input wire logic [15:0] rawSample,
	output logic sysTick
);
	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [7:0] clockControl_q;
	logic [7:0] syncConfig_q;
	logic [7:0] triggerConfig_q;
	logic [7:0] rdata_q;
	logic [2:0] mclkSync_q, bclkSync_q, fsSync_q, irqSync_q;
	logic mclkLvl_q, bclkLvl_q, fsLvl_q, irqLvl_q;
	logic [7:0] intCnt_q;
	logic [3:0] extCnt_q;
	logic tick_q;
	logic [7:0] sampleCnt_q;
	logic evtLvl_q;
	logic ready_q;
	logic [15:0] data_q;
	logic [15:0] prev_q;
	logic [15:0] prev2_q;
	logic sysTick_q;
	logic [1:0] clkSrc;
	logic [3:0] divVal;
	logic sarMode;
	logic extEdge;
	logic evtPin;
	logic evtRise;
	logic trigOn;
	logic [1:0] align;
	logic [16:0] avgSum;

	assign clkSrc = clockControl_q[stc_pkg::ClkSrcLsb +: 2];
	assign divVal = clockControl_q[stc_pkg::ExtDivLsb +: 4];
	assign sarMode = clockControl_q[stc_pkg::OpModeLsb +: 2] == stc_pkg::OpSar;
	assign align = syncConfig_q[stc_pkg::AlignLsb +: 2];
	// trigger path is valid only in the SAR chain, sync only in sigma-delta
	assign trigOn = triggerConfig_q[stc_pkg::TrigEnBit] & sarMode;

	// register writes; host keeps clock changes to standby
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clockControl_q <= stc_pkg::ClockControlReset;
			syncConfig_q <= stc_pkg::SyncConfigReset;
			triggerConfig_q <= stc_pkg::TriggerConfigReset;
		end else if (link.regWrite) begin
			case (link.regAddr)
				stc_pkg::ClockControlAddr: clockControl_q <= link.regWdata;
				stc_pkg::SyncConfigAddr: syncConfig_q <= link.regWdata;
				stc_pkg::TriggerConfigAddr: triggerConfig_q <= link.regWdata;
				default: ;
			endcase
		end
	end

	// read data stands one cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 8'h00;
		end else if (link.regRead) begin
			case (link.regAddr)
				stc_pkg::ClockControlAddr: rdata_q <= clockControl_q;
				stc_pkg::SyncConfigAddr: rdata_q <= syncConfig_q;
				stc_pkg::TriggerConfigAddr: rdata_q <= triggerConfig_q;
				stc_pkg::StatusAddr: rdata_q <= sampleCnt_q;
				default: rdata_q <= 8'h00;
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end

	// ------------------------------------------------------------
	// pin synchronisers: level changes once stages 2 and 3 agree
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mclkSync_q <= 3'h0;
			bclkSync_q <= 3'h0;
			fsSync_q <= 3'h0;
			irqSync_q <= 3'h0;
			mclkLvl_q <= 1'b0;
			bclkLvl_q <= 1'b0;
			fsLvl_q <= 1'b0;
			irqLvl_q <= 1'b0;
		end else begin
			mclkSync_q <= {mclkSync_q[1:0], link.masterClockPin};
			bclkSync_q <= {bclkSync_q[1:0], link.bitClockPin};
			fsSync_q <= {fsSync_q[1:0], link.frameSyncPin};
			irqSync_q <= {irqSync_q[1:0], link.irqPin1};
			if (mclkSync_q[2] == mclkSync_q[1]) mclkLvl_q <= mclkSync_q[2];
			if (bclkSync_q[2] == bclkSync_q[1]) bclkLvl_q <= bclkSync_q[2];
			if (fsSync_q[2] == fsSync_q[1]) fsLvl_q <= fsSync_q[2];
			if (irqSync_q[2] == irqSync_q[1]) irqLvl_q <= irqSync_q[2];
		end
	end

	// rising edge of the selected external clock pin
	assign extEdge = (clkSrc == stc_pkg::ClkMaster) ? (mclkSync_q[2] & mclkSync_q[1] & ~mclkLvl_q)
		: (bclkSync_q[2] & bclkSync_q[1] & ~bclkLvl_q);

	// ------------------------------------------------------------
	// system tick: internal divider or external divide by field+1
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			intCnt_q <= 8'h00;
			extCnt_q <= 4'h0;
			tick_q <= 1'b0;
		end else begin
			tick_q <= 1'b0;
			if (clkSrc == stc_pkg::ClkInternal) begin
				extCnt_q <= 4'h0;
				if (intCnt_q == 8'(stc_pkg::NominalDiv - 1)) begin
					intCnt_q <= 8'h00;
					tick_q <= 1'b1;
				end else begin
					intCnt_q <= intCnt_q + 8'h01;
				end
			end else if (extEdge) begin
				intCnt_q <= 8'h00;
				// ratio is field plus one, so 0011 gives divide by four
				if (extCnt_q >= divVal) begin
					extCnt_q <= 4'h0;
					tick_q <= 1'b1;
				end else begin
					extCnt_q <= extCnt_q + 4'h1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// sample event source: trigger, sync or free running
	// ------------------------------------------------------------
	always_comb begin
		if (trigOn) begin
			evtPin = triggerConfig_q[stc_pkg::TrigSelBit] ? irqLvl_q : fsLvl_q;
		end else begin
			evtPin = syncConfig_q[stc_pkg::SyncSelBit] ? irqLvl_q : fsLvl_q;
		end
	end
	assign evtRise = evtPin & ~evtLvl_q;
	assign avgSum = {1'b0, prev_q} + {1'b0, prev2_q};

	// sample counter, ready pulse and output data
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			evtLvl_q <= 1'b0;
			sampleCnt_q <= 8'h00;
			ready_q <= 1'b0;
			data_q <= 16'h0000;
			prev_q <= 16'h0000;
			prev2_q <= 16'h0000;
			sysTick_q <= 1'b0;
		end else begin
			evtLvl_q <= evtPin;
			ready_q <= 1'b0;
			sysTick_q <= tick_q;
			if (trigOn) begin
				// one sample per trigger edge, no free running output
				if (evtRise) begin
					data_q <= rawSample;
					ready_q <= 1'b1;
				end
			end else if (!sarMode && align == stc_pkg::StcAlignSync && evtRise) begin
				// restart the output period at the pulse
				sampleCnt_q <= 8'h00;
				data_q <= rawSample;
				ready_q <= 1'b1;
			end else if (!sarMode && align == stc_pkg::StcAlignInterp && evtRise) begin
				// average of last two samples, one period late
				data_q <= avgSum[16:1];
				ready_q <= 1'b1;
			end else if (tick_q) begin
				if (sampleCnt_q == 8'(stc_pkg::SamplePeriodTicks - 1)) begin
					sampleCnt_q <= 8'h00;
					prev2_q <= prev_q;
					prev_q <= rawSample;
					// interpolation mode reports only at pulses
					if (align != stc_pkg::StcAlignInterp || sarMode) begin
						data_q <= rawSample;
						ready_q <= 1'b1;
					end
				end else begin
					sampleCnt_q <= sampleCnt_q + 8'h01;
				end
			end
		end
	end

	// outputs straight from flip-flops
	assign link.regRdata = rdata_q;
	assign link.sampleReady = ready_q;
	assign link.sampleData = data_q;
	assign sysTick = sysTick_q;
endmodule
`default_nettype wire

// [verilog/stc_pkg.sv]
/*
 * stc_pkg: shared constants for the sample timing control block.
 * Assumes both ends of the link and the test side compile it first.
 */
package stc_pkg;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] ClockControlAddr = 8'h25;
	localparam logic [7:0] SyncConfigAddr = 8'h35;
	localparam logic [7:0] TriggerConfigAddr = 8'h49;
	localparam logic [7:0] StatusAddr = 8'h50;
	localparam logic [7:0] ClockControlReset = 8'h00;
	localparam logic [7:0] SyncConfigReset = 8'h00;
	localparam logic [7:0] TriggerConfigReset = 8'h00;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int ClkSrcLsb = 0;
	localparam int ExtDivLsb = 4;
	localparam int AlignLsb = 4;
	localparam int SyncSelBit = 6;
	localparam int TrigEnBit = 0;
	localparam int TrigSelBit = 1;
	// operating mode field in clock_control bits 3:2
	localparam int OpModeLsb = 2;
	localparam logic [1:0] OpSigmaDelta = 2'h0;
	localparam logic [1:0] OpSar = 2'h1;
	// ------------------------------------------------------------
	// encodings
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		StcAlignNone = 2'b00,
		StcAlignSync = 2'b01,
		StcAlignInterp = 2'b10
	} stc_align_t;
	localparam logic [1:0] ClkInternal = 2'h0;
	localparam logic [1:0] ClkMaster = 2'h1;
	localparam logic [1:0] ClkBit = 2'h2;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int ClkMhz = 100;
	localparam int NominalKhz = 1024;
	localparam int NominalDiv = (ClkMhz * 1000) / NominalKhz;
	localparam int PulseMinNs = 5700;
	localparam int PulseMinCycles = (PulseMinNs * ClkMhz + 999) / 1000;
	localparam int SamplePeriodTicks = 64;
	localparam int SampleWidth = 16;
endpackage

// [verilog/stc_link_if.sv]
/*
 * stc_link_if: pins between host and sensor timing block.
 * Assumes a single shared clk; pins are driven synchronously.
 */
`timescale 1ns/1ns
`default_nettype none
interface stc_link_if;
	logic masterClockPin;
	logic bitClockPin;
	logic frameSyncPin;
	logic irqPin1;
	logic [7:0] regAddr;
	logic [7:0] regWdata;
	logic regWrite;
	logic regRead;
	logic [7:0] regRdata;
	logic sampleReady;
	logic [15:0] sampleData;
	// ------------------------------------------------------------
	// party views
	// ------------------------------------------------------------
	modport device (input masterClockPin, bitClockPin, frameSyncPin, irqPin1, regAddr,
		regWdata, regWrite, regRead, output regRdata, sampleReady, sampleData);
	modport host (output masterClockPin, bitClockPin, frameSyncPin, irqPin1, regAddr,
		regWdata, regWrite, regRead, input regRdata, sampleReady, sampleData);
endinterface
`default_nettype wire

// [verilog/stc_host.sv]
/*
 * stc_host: timing master: makes external clock, pulses and register traffic.
 * Assumes the sensor end samples pins on the same clk.
 */
`timescale 1ns/1ns
`default_nettype none
module stc_host #(
	parameter int PulseCycles = stc_pkg::PulseMinCycles
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// link
	stc_link_if.host link,
	// user side
	input wire logic [7:0] cmdAddr,
	input wire logic [7:0] cmdWdata,
	input wire logic cmdWrite,
	input wire logic cmdRead,
	input wire logic clkRun,
	input wire logic useBitPin,
	input wire logic [3:0] clkHalfDiv,
	input wire logic pulseReq,
	input wire logic pulseOnIrq,
	output logic [7:0] rdData,
	output logic pulseBusy,
	output logic sampleSeen
);
	logic [3:0] halfCnt_q;
	logic extClk_q;
	logic [7:0] addr_q, wdata_q, rd_q;
	logic wr_q, rdS_q, rdD_q, busy_q, high_q, pin_q, seen_q, onIrq_q;
	logic [15:0] pCnt_q;
	logic bitSel_q;

	// clock out; toggles every clkHalfDiv+1 clk cycles while clkRun is high
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			halfCnt_q <= 4'h0;
			extClk_q <= 1'b0;
		end else if (clkRun) begin
			if (halfCnt_q >= clkHalfDiv) begin
				halfCnt_q <= 4'h0;
				extClk_q <= ~extClk_q;
			end else begin
				halfCnt_q <= halfCnt_q + 4'h1;
			end
		end
	end

	// register orders pass one cycle late; read data follows the device
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_q <= 8'h00;
			wdata_q <= 8'h00;
			wr_q <= 1'b0;
			rdS_q <= 1'b0;
			rdD_q <= 1'b0;
			rd_q <= 8'h00;
			seen_q <= 1'b0;
		end else begin
			addr_q <= cmdAddr;
			wdata_q <= cmdWdata;
			wr_q <= cmdWrite;
			rdS_q <= cmdRead & ~cmdWrite;
			rdD_q <= rdS_q;
			if (rdD_q) rd_q <= link.regRdata;
			seen_q <= link.sampleReady;
		end
	end

	// pin choice moves only while the clock is low, so the two pins never switch together;
	// a clock parked high keeps the old pin until it runs again
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bitSel_q <= 1'b0;
		end else if (!extClk_q) begin
			bitSel_q <= useBitPin;
		end
	end

	// pulses held high then low for the least width each
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_q <= 1'b0;
			high_q <= 1'b0;
			pin_q <= 1'b0;
			onIrq_q <= 1'b0;
			pCnt_q <= 16'h0000;
		end else if (!busy_q) begin
			if (pulseReq) begin
				busy_q <= 1'b1;
				high_q <= 1'b1;
				pin_q <= 1'b1;
				onIrq_q <= pulseOnIrq;
				pCnt_q <= 16'h0000;
			end
		end else if (pCnt_q == 16'(PulseCycles - 1)) begin
			pCnt_q <= 16'h0000;
			if (high_q) begin
				high_q <= 1'b0;
				pin_q <= 1'b0;
			end else begin
				busy_q <= 1'b0;
			end
		end else begin
			pCnt_q <= pCnt_q + 16'h0001;
		end
	end

	assign link.masterClockPin = extClk_q & ~bitSel_q;
	assign link.bitClockPin = extClk_q & bitSel_q;
	assign link.frameSyncPin = pin_q & ~onIrq_q;
	assign link.irqPin1 = pin_q & onIrq_q;
	assign link.regAddr = addr_q;
	assign link.regWdata = wdata_q;
	assign link.regWrite = wr_q;
	assign link.regRead = rdS_q;
	assign rdData = rd_q;
	assign pulseBusy = busy_q;
	assign sampleSeen = seen_q;
endmodule
`default_nettype wire

// [verification/stc_properties.sv]
/* stc_properties: link checks for the sample timing pair.
 * Assumes one clock and zero reset values in all registers. */
`timescale 1ns/1ns
`default_nettype none
module stc_properties (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// link
	input wire logic masterClockPin,
	input wire logic bitClockPin,
	input wire logic frameSyncPin,
	input wire logic irqPin1,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regRdata,
	input wire logic sampleReady,
	input wire logic [15:0] sampleData
);
	// --------
	// shadow state
	// --------
	logic [7:0] ctlQ;
	logic [7:0] syncQ;
	logic [7:0] trigQ;
	logic [7:0] expRd;
	logic [3:0] ageQ;
	logic sar;
	logic trigPin;
	logic syncPin;
	assign sar = ctlQ[3:2] == stc_pkg::OpSar;
	assign trigPin = trigQ[1] ? irqPin1 : frameSyncPin;
	assign syncPin = syncQ[6] ? irqPin1 : frameSyncPin;
	// status is left out of reads: it moves on its own
	always_comb begin
		case (regAddr)
			stc_pkg::ClockControlAddr: expRd = ctlQ;
			stc_pkg::SyncConfigAddr: expRd = syncQ;
			stc_pkg::TriggerConfigAddr: expRd = trigQ;
			default: expRd = 8'h00;
		endcase
	end
	// registers follow the writes on the link
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctlQ <= stc_pkg::ClockControlReset;
			syncQ <= stc_pkg::SyncConfigReset;
			trigQ <= stc_pkg::TriggerConfigReset;
		end else if (regWrite) begin
			if (regAddr == stc_pkg::ClockControlAddr) ctlQ <= regWdata;
			if (regAddr == stc_pkg::SyncConfigAddr) syncQ <= regWdata;
			if (regAddr == stc_pkg::TriggerConfigAddr) trigQ <= regWdata;
		end
	end
	// cycles since the last trigger edge, parked at 15
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) ageQ <= 4'hf;
		else if ($rose(trigPin)) ageQ <= 4'h0;
		else if (ageQ != 4'hf) ageQ <= ageQ + 4'h1;
	end
	// --------
	// properties
	// --------
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_strobes_apart: assert property (!(regWrite && regRead))
		else $error("both strobes high");
	a_rdata_idle: assert property (!$past(regRead) |-> regRdata == 8'h00)
		else $error("read data outside its cycle");
	a_reg_readback: assert property (
		regRead && regAddr != stc_pkg::StatusAddr |=> regRdata == $past(expRd))
		else $error("read data wrong");
	a_ready_pulse: assert property (sampleReady |=> !sampleReady)
		else $error("ready longer than one cycle");
	a_data_hold: assert property ($changed(sampleData) |-> sampleReady)
		else $error("data moved without ready");
	a_one_clock_pin: assert property (!($changed(masterClockPin) && $changed(bitClockPin)))
		else $error("both clock pins toggle");
	a_trig_answer: assert property (sar && trigQ[0] && $rose(trigPin) |-> ##[2:8] sampleReady)
		else $error("trigger not answered");
	a_trig_once: assert property (sar && trigQ[0] && sampleReady |-> ageQ < 4'ha)
		else $error("sample without trigger");
	a_sync_answer: assert property (
		ctlQ[3:2] == stc_pkg::OpSigmaDelta && syncQ[5:4] != 2'b00 && $rose(syncPin)
		|-> ##[2:8] sampleReady)
		else $error("sync not followed");
endmodule
`default_nettype wire

// [verification/sample_timing_control_bench.sv]
/* sample_timing_control_bench: drives the host user side and the device core.
 * Assumes orders pass one cycle late and rdData settles within five cycles. */
`timescale 1ns/1ns
`default_nettype none
module sample_timing_control_bench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] cmdAddr = 8'h00;
	logic [7:0] cmdWdata = 8'h00;
	logic cmdWrite = 1'b0;
	logic cmdRead = 1'b0;
	logic clkRun = 1'b0;
	logic useBitPin = 1'b0;
	logic [3:0] clkHalfDiv = 4'h1;
	logic pulseReq = 1'b0;
	logic pulseOnIrq = 1'b0;
	logic [15:0] rawSample = 16'h5a3c;
	logic [7:0] rdData;
	logic pulseBusy;
	logic sampleSeen;
	logic sysTick;
	int num_errors = 0;
	int checks = 0;
	stc_link_if link();
	stc_device u_stc_device (.clk(clk), .rst_n(rst_n), .link(link), .rawSample(rawSample),
		.sysTick(sysTick));
	stc_host #(.PulseCycles(stc_pkg::PulseMinCycles)) u_stc_host (.clk(clk), .rst_n(rst_n), .link(link),
		.cmdAddr(cmdAddr), .cmdWdata(cmdWdata), .cmdWrite(cmdWrite), .cmdRead(cmdRead),
		.clkRun(clkRun), .useBitPin(useBitPin), .clkHalfDiv(clkHalfDiv), .pulseReq(pulseReq),
		.pulseOnIrq(pulseOnIrq), .rdData(rdData), .pulseBusy(pulseBusy), .sampleSeen(sampleSeen));
	stc_properties u_stc_properties (.clk(clk), .rst_n(rst_n),
		.masterClockPin(link.masterClockPin), .bitClockPin(link.bitClockPin),
		.frameSyncPin(link.frameSyncPin), .irqPin1(link.irqPin1), .regAddr(link.regAddr),
		.regWdata(link.regWdata), .regWrite(link.regWrite), .regRead(link.regRead),
		.regRdata(link.regRdata), .sampleReady(link.sampleReady), .sampleData(link.sampleData));
	// 100 MHz
	always #5 clk = ~clk;
	// --------
	// shared tasks
	// --------
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t %s: got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		cmdAddr <= a;
		cmdWdata <= d;
		cmdWrite <= 1'b1;
		@(posedge clk);
		cmdWrite <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		cmdAddr <= a;
		cmdRead <= 1'b1;
		@(posedge clk);
		cmdRead <= 1'b0;
		repeat (4) @(posedge clk);
		d = rdData;
	endtask
	// answer lands within a dozen cycles, far inside a free-running sample period;
	// then the host finishes its full high and low widths before the next call
	task automatic pulse(input logic onIrq, output int n);
		n = 0;
		@(posedge clk);
		pulseOnIrq <= onIrq;
		pulseReq <= 1'b1;
		@(posedge clk);
		pulseReq <= 1'b0;
		repeat (16) begin
			@(posedge clk);
			#1 if (sampleSeen === 1'b1) n++;
		end
		while (pulseBusy !== 1'b0) begin
			@(posedge clk);
			#1;
		end
	endtask
	task automatic ticks(output int n);
		n = 0;
		repeat (800) begin
			@(posedge clk);
			#1 if (sysTick === 1'b1) n++;
		end
	endtask
	// --------
	// scenarios
	// --------
	task automatic t_regs;
		logic [7:0] d;
		rd(stc_pkg::ClockControlAddr, d);
		check(d, 8'h00, "clock reset");
		rd(stc_pkg::SyncConfigAddr, d);
		check(d, 8'h00, "sync reset");
		rd(stc_pkg::TriggerConfigAddr, d);
		check(d, 8'h00, "trig reset");
		wr(stc_pkg::SyncConfigAddr, 8'h60);
		rd(stc_pkg::SyncConfigAddr, d);
		check(d, 8'h60, "sync readback");
		rd(8'h7e, d);
		check(d, 8'h00, "unmapped read");
		wr(stc_pkg::SyncConfigAddr, 8'h00);
	endtask
	task automatic t_free;
		int n;
		n = 0;
		while (sampleSeen !== 1'b1 && n < 7000) begin
			@(posedge clk);
			#1 n++;
		end
		check(sampleSeen, 1'b1, "free sample");
		check(link.sampleData, rawSample, "sample value");
		ticks(n);
		check(n >= 8 && n <= 9, 1'b1, "internal tick rate");
	endtask
	task automatic t_ext;
		int n;
		int f;
		clkRun <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			f = i ? 3 : 7;
			useBitPin <= i[0];
			wr(stc_pkg::ClockControlAddr, {f[3:0], 2'h0, i[0] ? 2'h2 : 2'h1});
			ticks(n);
			check(n >= 800 / (4 * (f + 1)) - 1 && n <= 800 / (4 * (f + 1)) + 1, 1'b1,
				"external divide");
		end
		wr(stc_pkg::ClockControlAddr, 8'h00);
		clkRun <= 1'b0;
	endtask
	task automatic t_trig;
		int n;
		wr(stc_pkg::ClockControlAddr, 8'h04);
		for (int s = 0; s < 2; s++) begin
			wr(stc_pkg::TriggerConfigAddr, {6'h00, s[0], 1'b1});
			pulse(s[0], n);
			check(n, 1, "one sample per trigger");
			pulse(!s[0], n);
			check(n, 0, "unselected pin");
		end
		wr(stc_pkg::TriggerConfigAddr, 8'h00);
		pulse(1'b0, n);
		check(n, 0, "trigger off");
		wr(stc_pkg::ClockControlAddr, 8'h00);
		wr(stc_pkg::TriggerConfigAddr, 8'h01);
		pulse(1'b0, n);
		check(n, 0, "trigger in sigma-delta");
		wr(stc_pkg::TriggerConfigAddr, 8'h00);
	endtask
	task automatic t_sync;
		int n;
		logic [7:0] d;
		logic [15:0] old;
		old = rawSample;
		for (int m = 1; m < 3; m++) begin
			wr(stc_pkg::SyncConfigAddr, {1'b0, m[1], m[1:0], 4'h0});
			// a fresh core value shows whether interpolation really averages older samples
			if (m == 2) rawSample <= 16'h1234;
			pulse(m[1], n);
			check(n, 1, "sync sample");
			check(link.sampleData, (m == 2) ? old : rawSample, "aligned value");
			if (m == 1) begin
				// period counter restarted at the pulse, about a dozen ticks ago
				rd(stc_pkg::StatusAddr, d);
				check(d >= 8'h0a && d <= 8'h0d, 1'b1, "realigned period");
			end
		end
		wr(stc_pkg::ClockControlAddr, 8'h04);
		pulse(1'b1, n);
		check(n, 0, "sync in SAR");
		wr(stc_pkg::ClockControlAddr, 8'h00);
		wr(stc_pkg::SyncConfigAddr, 8'h00);
		pulse(1'b0, n);
		check(n, 0, "no alignment");
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_regs();
		t_free();
		t_ext();
		t_trig();
		t_sync();
		end_of_test();
	end
	// watchdog: the tests take about 20100 cycles
	initial begin
		repeat (40000) @(posedge clk);
		num_errors++;
		end_of_test();
	end
endmodule
`default_nettype wire
